/* bench/ross_relay_watch.sv */
// Model of the equipment that watches the two contacts.
`timescale 1ns/100ps
module ross_relay_watch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic relay_one_out,
  input wire logic open_collector_output,
  output logic [15:0] closures
);
  // Contacts are outputs only, so the watcher never drives anything back.
  logic [1:0] last_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_q <= 2'h0;
      closures <= 16'h0000;
    end else begin
      last_q <= {open_collector_output, relay_one_out};
      closures <= closures + 16'(relay_one_out & !last_q[0])
        + 16'(open_collector_output & !last_q[1]);
    end
  end
endmodule : ross_relay_watch

/* bench/ross_top_bench.sv */
// Self-checking bench for relay output source selection.
`timescale 1ns/100ps
`include "ross_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module ross_top_bench;
  logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, r1, r2, brk;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dato, seed = 32'hd79f;
  logic [15:0] of = 16'h0, opf = 16'h0, dcv = 16'h0, thr = 16'h0;
  logic [20:0] st = 21'h0;
  int fails = 0, comparisons = 0;
  always #10 clk = ~clk;
  ross_top uut (.clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dato), .wb_ack_o(ack), .out_freq(of),
    .op_freq(opf), .accel(st[0]), .decel(st[1]), .motor_overload(st[2]),
    .drive_overload_fault(st[3]), .underload_warn(st[4]), .fan_warn(st[5]),
    .motor_stall(st[6]), .dc_volt(dcv), .dc_overvolt(st[7]), .dc_lowvolt(st[8]),
    .overheat(st[9]), .analog_ref_lost(st[10]), .comm_cmd_lost(st[11]), .run_cmd(st[12]),
    .output_voltage_on(st[13]), .dc_braking(st[14]), .drive_line_active(st[15]),
    .line_xfer_input(st[16]), .speed_search_active(st[17]), .regen_mode(st[18]),
    .drive_ready(st[19]), .fault_trip(st[20]), .relay_one_out(r1),
    .open_collector_output(r2), .brake_resistor_on(brk));
  ross_relay_watch peer (.clk, .sys_rst, .relay_one_out(r1), .open_collector_output(r2),
    .closures());
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic want(input logic [5:0] c, input logic [20:0] s);
    if (c inside {5, 6, 7, 8, 10, 11, 12, 21, 22}) return s[c - 3];
    if (c inside {[17:19]}) return s[c - 2];
    case (c)
      9: return s[2] & s[6];
      13: return s[10] | s[11];
      14: return s[12] & s[13] & !s[14];
      15: return !s[12] & !s[13];
      16: return !s[0] & !s[1];
      29: return s[20];
      default: return 1'b0;
    endcase
  endfunction : want
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Entered just after an edge; returns one idle cycle after the release.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rdat = dato;
    if (n >= 20) begin fails++; end_of_test(); end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic step(input logic [5:0] c1, input logic [5:0] c2);
    seed = xs(seed);
    st <= seed[20:0];
    dcv <= seed[31:16];
    @(posedge clk);
    #1;
    `CHK("relay one", want(c1, st), r1)
    `CHK("relay two", want(c2, st), r2)
    `CHK("brake", st[12] & st[13] & (dcv > thr), brk)
    @(posedge clk);
  endtask : step
  task automatic fq(input logic [15:0] o, input logic [15:0] p, input logic [1:0] ad,
      input logic e1, input logic e2);
    of <= o;
    opf <= p;
    st <= {19'h0, ad};
    repeat (3) @(posedge clk);
    #1;
    `CHK("band match", e1, r1)
    `CHK("threshold", e2, r2)
    @(posedge clk);
  endtask : fq
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, `ROSS_ADR_RELAY1, 32'h0);
    `CHK("relay one select", 32'h1d, rdat)
    bus(1'b0, `ROSS_ADR_RELAY2, 32'h0);
    `CHK("relay two select", 32'h0e, rdat)
    bus(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    repeat (6) step(6'h1d, 6'h0e);
    bus(1'b1, `ROSS_ADR_BRKTHR, 32'h8000);
    thr = 16'h8000;
    for (int c = 0; c < 32; c++) begin
      if (c inside {3, 4, 27, 28}) continue;
      bus(1'b1, `ROSS_ADR_RELAY1, 32'(c));
      bus(1'b1, `ROSS_ADR_RELAY2, 32'(31 - c));
      repeat (10) step(6'(c), 6'(31 - c));
    end
    bus(1'b1, `ROSS_ADR_RELAY1, 32'h3);
    bus(1'b1, `ROSS_ADR_RELAY2, 32'h4);
    fq(16'd3499, 16'd3000, 2'b01, 1'b1, 1'b1);
    fq(16'd3500, 16'd2999, 2'b01, 1'b0, 1'b0);
    fq(16'd2501, 16'd3000, 2'b00, 1'b1, 1'b0);
    fq(16'd3000, 16'd2501, 2'b10, 1'b1, 1'b1);
    fq(16'd3000, 16'd2500, 2'b10, 1'b0, 1'b0);
    fq(16'd0, 16'd3000, 2'b01, 1'b0, 1'b1);
    fq(16'd0, 16'd0, 2'b00, 1'b1, 1'b1);
    bus(1'b0, `ROSS_ADR_STATUS, 32'h0);
    `CHK("status", 32'h0000000b, rdat)
    end_of_test();
  end
endmodule : ross_top_bench

/* bench/ross_top_sva.sv */
// Assertions on the relay output source selection ports.
`timescale 1ns/100ps
module ross_top_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic motor_overload,
  input wire logic fault_trip,
  input wire logic run_cmd,
  input wire logic output_voltage_on,
  input wire logic dc_braking,
  input wire logic [15:0] dc_volt,
  input wire logic relay_one_out,
  input wire logic open_collector_output,
  input wire logic brake_resistor_on
);
  // Mirrors follow the taking edge, which is when the block itself stores a write.
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [15:0] thr_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 6'h1d;
      s2_q <= 6'h0e;
      thr_q <= 16'h0000;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == 8'h00) s1_q <= wb_dat_i[5:0];
      if (wb_adr_i == 8'h04) s2_q <= wb_dat_i[5:0];
      if (wb_adr_i == 8'h10) thr_q <= wb_dat_i[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  bus_answer_a: assert property (bus_req |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  trip_default_a: assert property (s1_q == 6'h1d |=> relay_one_out == $past(fault_trip))
    else $error("relay one does not follow the trip status");
  overload_follow_a: assert property (s1_q == 6'h05 |=> relay_one_out == $past(motor_overload))
    else $error("relay one does not follow motor overload");
  stop_state_a: assert property (s1_q == 6'h0f |=>
    relay_one_out == $past(!run_cmd && !output_voltage_on)) else $error("stop status wrong");
  run_default_a: assert property (s2_q == 6'h0e |=>
    open_collector_output == $past(run_cmd && output_voltage_on && !dc_braking))
    else $error("second output does not show run status");
  brake_level_a: assert property (##1 brake_resistor_on ==
    $past(run_cmd && output_voltage_on && (dc_volt > thr_q))) else $error("brake level wrong");
  brake_idle_a: assert property (!run_cmd |=> !brake_resistor_on)
    else $error("brake on without run command");
endmodule : ross_top_sva
bind ross_top ross_top_sva chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_ack_o, .motor_overload, .fault_trip, .run_cmd, .output_voltage_on,
  .dc_braking, .dc_volt, .relay_one_out, .open_collector_output, .brake_resistor_on);

/* core/ross_params.svh */
// Constants for the relay output source selection block.
`ifndef ROSS_PARAMS_SVH
`define ROSS_PARAMS_SVH
`define ROSS_SEL_W 6
`define ROSS_FREQ_W 16
`define ROSS_SEL_NONE 6'h00
`define ROSS_SEL_FDT1 6'h01
`define ROSS_SEL_FDT2 6'h02
`define ROSS_SEL_FDT3 6'h03
`define ROSS_SEL_FDT4 6'h04
`define ROSS_SEL_OVERLOAD 6'h05
`define ROSS_SEL_DRV_OL 6'h06
`define ROSS_SEL_UNDERLOAD 6'h07
`define ROSS_SEL_FAN 6'h08
`define ROSS_SEL_STALL 6'h09
`define ROSS_SEL_OVERVOLT 6'h0a
`define ROSS_SEL_LOWVOLT 6'h0b
`define ROSS_SEL_OVERHEAT 6'h0c
`define ROSS_SEL_LOSTCMD 6'h0d
`define ROSS_SEL_RUN 6'h0e
`define ROSS_SEL_STOP 6'h0f
`define ROSS_SEL_STEADY 6'h10
`define ROSS_SEL_DRV_LINE 6'h11
`define ROSS_SEL_XFER 6'h12
`define ROSS_SEL_SSEARCH 6'h13
`define ROSS_SEL_REGEN 6'h15
`define ROSS_SEL_READY 6'h16
`define ROSS_SEL_TRIP 6'h1d
`define ROSS_ADR_RELAY1 8'h00
`define ROSS_ADR_RELAY2 8'h04
`define ROSS_ADR_DETFREQ 8'h08
`define ROSS_ADR_DETBAND 8'h0c
`define ROSS_ADR_BRKTHR 8'h10
`define ROSS_ADR_STATUS 8'h14
`define ROSS_RST_DETFREQ 16'h0bb8
`define ROSS_RST_DETBAND 16'h03e8
`define ROSS_RST_BRKTHR 16'h0000
`endif

/* core/ross_pkg.sv */
// Types shared by the relay output source selection block.
package ross_pkg;
  typedef logic [5:0] ross_sel_t;
  typedef logic [15:0] ross_freq_t;
endpackage : ross_pkg

/* core/ross_top.sv */
// Relay output source selection with Wishbone register access.
// Notes on behaviour
// - Mode 3: |out-op| below half band.
// - Mode 4 accelerating: op at/above detect.
// - Mode 4 decelerating: op above detect-half band.
// - Code 5 follows motor overload.
// - Code 6 follows drive overload fault.
// - Code 7 follows underload warning.
// - Code 8 follows fan fault warning.
// - Code 9 follows overload with stall.
// - Code 10 follows DC overvoltage.
// - Code 11 follows DC low voltage.
// - Code 12 follows drive overheat.
// - Code 13 on lost analog/serial command.
// - Code 15 no run, no voltage.
// - Code 16 steady speed.
// - Code 17 motor on drive line.
// - Code 18 line-transfer input active.
// - Code 19 speed search active.
// - Code 21 regeneration mode.
// - Brake resistor with run command and voltage on, DC volts above threshold.
// - Code 22 ready for external run.
// - Relay one resets to trip code.
// - Relay two resets to run code.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "ross_params.svh"
module ross_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] op_freq,
  input wire logic accel,
  input wire logic decel,
  input wire logic motor_overload,
  input wire logic drive_overload_fault,
  input wire logic underload_warn,
  input wire logic fan_warn,
  input wire logic motor_stall,
  input wire logic [15:0] dc_volt,
  input wire logic dc_overvolt,
  input wire logic dc_lowvolt,
  input wire logic overheat,
  input wire logic analog_ref_lost,
  input wire logic comm_cmd_lost,
  input wire logic run_cmd,
  input wire logic output_voltage_on,
  input wire logic dc_braking,
  input wire logic drive_line_active,
  input wire logic line_xfer_input,
  input wire logic speed_search_active,
  input wire logic regen_mode,
  input wire logic drive_ready,
  input wire logic fault_trip,
  output logic relay_one_out,
  output logic open_collector_output,
  output logic brake_resistor_on
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  ross_pkg::ross_sel_t relay_one_source_select_q;
  ross_pkg::ross_sel_t relay_two_source_select_q;
  ross_pkg::ross_freq_t det_freq_q;
  ross_pkg::ross_freq_t det_band_q;
  ross_pkg::ross_freq_t brk_thr_q;
  logic fdt4_q;
  logic wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  logic wb_wr;
  assign wb_wr = wb_req && wb_we_i;

  // Writes land at the taking edge; byte lanes gate each half of a wide register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      relay_one_source_select_q <= `ROSS_SEL_TRIP;
    end else if (wb_wr && (wb_adr_i == `ROSS_ADR_RELAY1) && wb_sel_i[0]) begin
      relay_one_source_select_q <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      relay_two_source_select_q <= `ROSS_SEL_RUN;
    end else if (wb_wr && (wb_adr_i == `ROSS_ADR_RELAY2) && wb_sel_i[0]) begin
      relay_two_source_select_q <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      det_freq_q <= `ROSS_RST_DETFREQ;
    end else if (wb_wr && (wb_adr_i == `ROSS_ADR_DETFREQ)) begin
      if (wb_sel_i[0]) begin
        det_freq_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        det_freq_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      det_band_q <= `ROSS_RST_DETBAND;
    end else if (wb_wr && (wb_adr_i == `ROSS_ADR_DETBAND)) begin
      if (wb_sel_i[0]) begin
        det_band_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        det_band_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_thr_q <= `ROSS_RST_BRKTHR;
    end else if (wb_wr && (wb_adr_i == `ROSS_ADR_BRKTHR)) begin
      if (wb_sel_i[0]) begin
        brk_thr_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        brk_thr_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Unmapped addresses still acknowledge and read as zero, so a stray access never hangs.
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h00000000;
    case (wb_adr_i)
      `ROSS_ADR_RELAY1: rd_d = {26'h0000000, relay_one_source_select_q};
      `ROSS_ADR_RELAY2: rd_d = {26'h0000000, relay_two_source_select_q};
      `ROSS_ADR_DETFREQ: rd_d = {16'h0000, det_freq_q};
      `ROSS_ADR_DETBAND: rd_d = {16'h0000, det_band_q};
      `ROSS_ADR_BRKTHR: rd_d = {16'h0000, brk_thr_q};
      `ROSS_ADR_STATUS: rd_d = {28'h0000000, fdt4_q, brake_resistor_on,
                                open_collector_output, relay_one_out};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data holds until the next read, so a slow master can still take it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  // ----------------------------------------
  // Frequency detection
  // ----------------------------------------
  logic [15:0] half_band;
  logic [15:0] freq_diff;
  logic [16:0] hyst_level;
  logic freq_detect_band_match;
  logic freq_detect_threshold_hyst;

  assign half_band = {1'b0, det_band_q[15:1]};
  assign freq_diff = (out_freq >= op_freq) ? out_freq - op_freq : op_freq - out_freq;
  assign freq_detect_band_match = freq_diff < half_band;
  // The low level may go negative; a signed margin keeps the compare honest.
  assign hyst_level = {1'b0, det_freq_q} - {1'b0, half_band};

  // Holding the last state outside accel and decel keeps the output steady at constant speed.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fdt4_q <= 1'b0;
    end else if (accel) begin
      fdt4_q <= op_freq >= det_freq_q;
    end else if (decel) begin
      fdt4_q <= hyst_level[16] || ({1'b0, op_freq} > hyst_level);
    end
  end
  assign freq_detect_threshold_hyst = fdt4_q;

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Derived conditions are named once so both selectors see identical levels.
  logic steady_speed;
  logic stopped;
  logic running;
  logic lost_command;
  logic stall_overload;

  assign steady_speed = !accel && !decel;
  assign stopped = !run_cmd && !output_voltage_on;
  assign running = run_cmd && output_voltage_on && !dc_braking;
  assign lost_command = analog_ref_lost || comm_cmd_lost;
  assign stall_overload = motor_overload && motor_stall;

  ross_relay_pick relay_one_pick (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(relay_one_source_select_q),
    .band_match(freq_detect_band_match),
    .threshold_hyst(freq_detect_threshold_hyst),
    .motor_overload(motor_overload),
    .drive_overload_fault(drive_overload_fault),
    .underload_warn(underload_warn),
    .fan_warn(fan_warn),
    .stall_overload(stall_overload),
    .dc_overvolt(dc_overvolt),
    .dc_lowvolt(dc_lowvolt),
    .overheat(overheat),
    .lost_command(lost_command),
    .running(running),
    .stopped(stopped),
    .steady_speed(steady_speed),
    .drive_line_active(drive_line_active),
    .line_xfer_input(line_xfer_input),
    .speed_search_active(speed_search_active),
    .regen_mode(regen_mode),
    .drive_ready(drive_ready),
    .fault_trip(fault_trip),
    .relay_out(relay_one_out)
  );

  ross_relay_pick relay_two_pick (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(relay_two_source_select_q),
    .band_match(freq_detect_band_match),
    .threshold_hyst(freq_detect_threshold_hyst),
    .motor_overload(motor_overload),
    .drive_overload_fault(drive_overload_fault),
    .underload_warn(underload_warn),
    .fan_warn(fan_warn),
    .stall_overload(stall_overload),
    .dc_overvolt(dc_overvolt),
    .dc_lowvolt(dc_lowvolt),
    .overheat(overheat),
    .lost_command(lost_command),
    .running(running),
    .stopped(stopped),
    .steady_speed(steady_speed),
    .drive_line_active(drive_line_active),
    .line_xfer_input(line_xfer_input),
    .speed_search_active(speed_search_active),
    .regen_mode(regen_mode),
    .drive_ready(drive_ready),
    .fault_trip(fault_trip),
    .relay_out(open_collector_output)
  );

  // Braking is an output of its own, not a relay code, so it bypasses the selectors.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brake_resistor_on <= 1'b0;
    end else begin
      brake_resistor_on <= run_cmd && output_voltage_on && (dc_volt > brk_thr_q);
    end
  end

endmodule : ross_top

// Picks one status condition by selection code and registers it as a contact drive.
module ross_relay_pick (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ross_pkg::ross_sel_t code,
  input wire logic band_match,
  input wire logic threshold_hyst,
  input wire logic motor_overload,
  input wire logic drive_overload_fault,
  input wire logic underload_warn,
  input wire logic fan_warn,
  input wire logic stall_overload,
  input wire logic dc_overvolt,
  input wire logic dc_lowvolt,
  input wire logic overheat,
  input wire logic lost_command,
  input wire logic running,
  input wire logic stopped,
  input wire logic steady_speed,
  input wire logic drive_line_active,
  input wire logic line_xfer_input,
  input wire logic speed_search_active,
  input wire logic regen_mode,
  input wire logic drive_ready,
  input wire logic fault_trip,
  output logic relay_out
);

  logic relay_d;

  always_comb begin
    relay_d = 1'b0;
    case (code)
      `ROSS_SEL_FDT3: relay_d = band_match;
      `ROSS_SEL_FDT4: relay_d = threshold_hyst;
      `ROSS_SEL_OVERLOAD: relay_d = motor_overload;
      `ROSS_SEL_DRV_OL: relay_d = drive_overload_fault;
      `ROSS_SEL_UNDERLOAD: relay_d = underload_warn;
      `ROSS_SEL_FAN: relay_d = fan_warn;
      `ROSS_SEL_STALL: relay_d = stall_overload;
      `ROSS_SEL_OVERVOLT: relay_d = dc_overvolt;
      `ROSS_SEL_LOWVOLT: relay_d = dc_lowvolt;
      `ROSS_SEL_OVERHEAT: relay_d = overheat;
      `ROSS_SEL_LOSTCMD: relay_d = lost_command;
      `ROSS_SEL_RUN: relay_d = running;
      `ROSS_SEL_STOP: relay_d = stopped;
      `ROSS_SEL_STEADY: relay_d = steady_speed;
      `ROSS_SEL_DRV_LINE: relay_d = drive_line_active;
      `ROSS_SEL_XFER: relay_d = line_xfer_input;
      `ROSS_SEL_SSEARCH: relay_d = speed_search_active;
      `ROSS_SEL_REGEN: relay_d = regen_mode;
      `ROSS_SEL_READY: relay_d = drive_ready;
      `ROSS_SEL_TRIP: relay_d = fault_trip;
      default: relay_d = 1'b0;
    endcase
  end

  // A registered drive keeps select changes and input glitches off the contact.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      relay_out <= 1'b0;
    end else begin
      relay_out <= relay_d;
    end
  end

endmodule : ross_relay_pick
